// file: common/zqcal_pkg.sv
// shared constants and types for the impedance calibration link
package zqcal_pkg;
	localparam int unsigned CLK_MHZ        = 50;
	localparam int unsigned CNT_W          = 24;
	// timing periods in nanoseconds; calibration ones are defaults only, precharge and exit times used directly
	localparam int unsigned T_ZQINIT_NS    = 20480;
	localparam int unsigned T_ZQOPER_NS    = 10240;
	localparam int unsigned T_ZQCS_NS      = 2560;
	localparam int unsigned T_RP_NS        = 15;
	localparam int unsigned T_XSF_NS       = 500;
	localparam int unsigned ZQINIT_CYC     = (T_ZQINIT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned ZQOPER_CYC     = (T_ZQOPER_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned ZQCS_CYC       = (T_ZQCS_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RP_CYC         = (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned XSF_CYC        = (T_XSF_NS * CLK_MHZ + 999) / 1000;
	// short calibration corrects one step within this many clocks
	localparam int unsigned ZQCS_STEP_CYC  = 64;
	localparam logic [7:0]  CODE_RESET     = 8'h80;
	localparam logic [7:0]  CODE_STEP      = 8'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO  = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_ONE   = 24'h000001;

	typedef enum logic [1:0] {
		ZQCAL_NONE,
		ZQCAL_LONG,
		ZQCAL_SHORT
	} zqcal_cmd_t;
endpackage

// file: common/zqcal_if.sv
// command link between controller and device calibration ends
`timescale 1ns/1ps
interface zqcal_if;
	logic                 cke;
	logic                 odt;
	logic                 cal_cmd_vld;
	zqcal_pkg::zqcal_cmd_t cal_cmd;
	logic                 dq_oe_ctl;
	logic                 dev_busy;

	modport ctl (
		output cke,
		output odt,
		output cal_cmd_vld,
		output cal_cmd,
		output dq_oe_ctl,
		input  dev_busy
	);
	modport dev (
		input  cke,
		input  odt,
		input  cal_cmd_vld,
		input  cal_cmd,
		input  dq_oe_ctl,
		output dev_busy
	);
endinterface

// file: core/zqcal_dev.sv
// device end: calibration engine, value transfer and termination override
`timescale 1ns/1ps
// Overview of operation
// - long calibration at power-up, any later time
// - long command runs engine, then transfers values
// - first long after reset gets init period
// - short command corrects drift within short period
// - short command corrects one step per 64 clocks
// - controller repeats short at the programmed interval
// - controller keeps channel quiet during calibration
// - device disables calibration current when done
// - controller waits for banks idle, then precharge time
// - no recalibration after self refresh without command
// - controller waits exit time after self refresh
// - shared resistor: controller never overlaps devices
// - clock enable held high during calibration
// - termination off during calibration, forced if needed
// - all data outputs high impedance during calibration
module zqcal_dev (
	// clock, reset, enable
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             clk_en_i,
	// link
	zqcal_if.dev                  link,
	// user side
	input  wire logic [7:0]       target_code_i,
	input  wire logic             sr_exit_i,
	output logic      [7:0]       io_code_o,
	output logic                  cal_current_en_o,
	output logic                  term_en_o,
	output logic                  long_done_o,
	output logic                  cal_err_o
);
	typedef enum logic [1:0] {
		ZQD_IDLE,
		ZQD_LONG,
		ZQD_SHORT
	} zqcal_dev_st_t;

	zqcal_dev_st_t    st_r, st_nxt;
	logic [7:0]       eng_r, eng_nxt;
	logic [7:0]       io_r, io_nxt;
	logic [7:0]       step_r, step_nxt;
	logic             cur_r, cur_nxt;
	logic             term_r, term_nxt;
	logic             long_r, long_nxt;
	logic             err_r, err_nxt;
	logic             busy_r, busy_nxt;
	logic [zqcal_pkg::CNT_W-1:0] xsf_r, xsf_nxt;
	logic             cmd_long;
	logic             cmd_short;

	function automatic logic [7:0] zqd_toward(input logic [7:0] cur, input logic [7:0] tgt);
		if (cur < tgt)
			return cur + zqcal_pkg::CODE_STEP;
		else if (cur > tgt)
			return cur - zqcal_pkg::CODE_STEP;
		else
			return cur;
	endfunction

	function automatic logic zqd_cmd_is(input logic vld, input zqcal_pkg::zqcal_cmd_t cmd,
		input zqcal_pkg::zqcal_cmd_t kind);
		return vld && (cmd == kind);
	endfunction

	// commands only start a run while idle; a busy engine does not run them, the fault watch flags them
	assign cmd_long  = zqd_cmd_is(link.cal_cmd_vld, link.cal_cmd, zqcal_pkg::ZQCAL_LONG);
	assign cmd_short = zqd_cmd_is(link.cal_cmd_vld, link.cal_cmd, zqcal_pkg::ZQCAL_SHORT);

	// sequencer: run state, short-run step, busy and current path
	always_comb begin
		st_nxt   = st_r;
		step_nxt = step_r;
		cur_nxt  = cur_r;
		busy_nxt = busy_r;
		case (st_r)
			ZQD_IDLE: begin
				// self refresh exit alone starts nothing
				if (cmd_long) begin
					st_nxt   = ZQD_LONG;
					cur_nxt  = 1'b1;
					busy_nxt = 1'b1;
				end else if (cmd_short) begin
					st_nxt   = ZQD_SHORT;
					step_nxt = 8'h00;
					cur_nxt  = 1'b1;
					busy_nxt = 1'b1;
				end
			end

			ZQD_LONG: begin
				if (eng_r == target_code_i) begin
					cur_nxt  = 1'b0;
					busy_nxt = 1'b0;
					st_nxt   = ZQD_IDLE;
				end
			end

			ZQD_SHORT: begin
				step_nxt = step_r + 8'h01;
				if (step_r == 8'h01) begin
					cur_nxt  = 1'b0;
					busy_nxt = 1'b0;
					st_nxt   = ZQD_IDLE;
				end
			end

			default: st_nxt = ZQD_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r   <= ZQD_IDLE;
			step_r <= 8'h00;
			cur_r  <= 1'b0;
			busy_r <= 1'b0;
		end else if (clk_en_i) begin
			st_r   <= st_nxt;
			step_r <= step_nxt;
			cur_r  <= cur_nxt;
			busy_r <= busy_nxt;
		end
	end

	// codes: engine walks toward the sensed target, io takes it on transfer
	always_comb begin
		eng_nxt  = eng_r;
		io_nxt   = io_r;
		long_nxt = long_r;
		case (st_r)
			ZQD_IDLE: begin
				if (cmd_long)
					eng_nxt = zqcal_pkg::CODE_RESET;
				else if (cmd_short)
					eng_nxt = io_r;
			end

			ZQD_LONG: begin
				if (eng_r == target_code_i) begin
					io_nxt   = eng_r;
					long_nxt = 1'b1;
				end else begin
					eng_nxt = zqd_toward(eng_r, target_code_i);
				end
			end

			ZQD_SHORT: begin
				// one code step well inside the 64-clock bound
				if (step_r == 8'h00)
					eng_nxt = zqd_toward(eng_r, target_code_i);
				if (step_r == 8'h01)
					io_nxt = eng_r;
			end

			default: eng_nxt = eng_r;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eng_r  <= zqcal_pkg::CODE_RESET;
			io_r   <= zqcal_pkg::CODE_RESET;
			long_r <= 1'b0;
		end else if (clk_en_i) begin
			eng_r  <= eng_nxt;
			io_r   <= io_nxt;
			long_r <= long_nxt;
		end
	end

	// termination: off through any run and on a self refresh exit pulse
	always_comb begin
		term_nxt = link.odt;
		if (st_r != ZQD_IDLE || st_nxt != ZQD_IDLE || sr_exit_i)
			term_nxt = 1'b0;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			term_r <= 1'b0;
		else if (clk_en_i)
			term_r <= term_nxt;
	end

	// fault watch: sticky, so a spoiled result is never silently used
	always_comb begin
		xsf_nxt = xsf_r;
		err_nxt = err_r;
		if (sr_exit_i)
			xsf_nxt = zqcal_pkg::CNT_ZERO + zqcal_pkg::XSF_CYC[zqcal_pkg::CNT_W-1:0];
		else if (xsf_r != zqcal_pkg::CNT_ZERO)
			xsf_nxt = xsf_r - zqcal_pkg::CNT_ONE;
		// dropping clock enable mid-run spoils the result
		if (st_r != ZQD_IDLE && !link.cke)
			err_nxt = 1'b1;
		// command on a busy engine or inside the exit guard
		if (link.cal_cmd_vld && (busy_r || xsf_r != zqcal_pkg::CNT_ZERO))
			err_nxt = 1'b1;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xsf_r <= zqcal_pkg::CNT_ZERO;
			err_r <= 1'b0;
		end else if (clk_en_i) begin
			xsf_r <= xsf_nxt;
			err_r <= err_nxt;
		end
	end

	assign io_code_o        = io_r;
	assign cal_current_en_o = cur_r;
	assign term_en_o        = term_r;
	assign long_done_o      = long_r;
	assign cal_err_o        = err_r;
	assign link.dev_busy    = busy_r;
endmodule

// file: core/zqcal_ctl.sv
// controller end: schedules long and short calibration with quiet windows
`timescale 1ns/1ps
module zqcal_ctl (
	// clock, reset, enable
	input  wire logic                        core_clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        clk_en_i,
	// link
	zqcal_if.ctl                             link,
	// programmable periods in cycles
	input  wire logic [zqcal_pkg::CNT_W-1:0] zqinit_cyc_i,
	input  wire logic [zqcal_pkg::CNT_W-1:0] zqoper_cyc_i,
	input  wire logic [zqcal_pkg::CNT_W-1:0] zqcs_cyc_i,
	input  wire logic [zqcal_pkg::CNT_W-1:0] zqcs_interval_i,
	// requests and system status
	input  wire logic                        long_req_i,
	input  wire logic                        short_req_i,
	input  wire logic                        banks_idle_i,
	input  wire logic                        sr_exit_i,
	input  wire logic                        zq_grant_i,
	input  wire logic                        odt_req_i,
	// status
	output logic                             busy_o,
	output logic                             quiet_o,
	output logic                             zq_hold_o,
	output logic                             first_long_done_o
);
	typedef enum logic [1:0] {
		ZQC_IDLE,
		ZQC_WAIT,
		ZQC_CAL
	} zqcal_ctl_st_t;

	zqcal_ctl_st_t           st_r, st_nxt;
	logic                    long_seen_r, long_seen_nxt;
	logic                    is_long_r, is_long_nxt;
	logic [zqcal_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic [zqcal_pkg::CNT_W-1:0] pre_r, pre_nxt;
	logic [zqcal_pkg::CNT_W-1:0] ivl_r, ivl_nxt;
	logic                    vld_r, vld_nxt;
	zqcal_pkg::zqcal_cmd_t   cmd_r, cmd_nxt;
	logic                    odt_r, odt_nxt;
	logic                    pend_l_r, pend_l_nxt;
	logic                    pend_s_r, pend_s_nxt;
	logic                    busy_r, busy_nxt;
	logic                    quiet_r, quiet_nxt;
	logic                    dq_oe_r, dq_oe_nxt;

	always_comb begin
		st_nxt        = st_r;
		long_seen_nxt = long_seen_r;
		is_long_nxt   = is_long_r;
		cnt_nxt       = cnt_r;
		vld_nxt       = 1'b0;
		cmd_nxt       = zqcal_pkg::ZQCAL_NONE;
		odt_nxt       = odt_req_i;
		pend_l_nxt    = pend_l_r | long_req_i;
		pend_s_nxt    = pend_s_r | short_req_i;
		// precharge and self-refresh-exit guard
		if (sr_exit_i)
			pre_nxt = zqcal_pkg::CNT_ZERO + zqcal_pkg::XSF_CYC[zqcal_pkg::CNT_W-1:0];
		else if (!banks_idle_i)
			pre_nxt = zqcal_pkg::CNT_ZERO + zqcal_pkg::RP_CYC[zqcal_pkg::CNT_W-1:0];
		else if (pre_r != zqcal_pkg::CNT_ZERO)
			pre_nxt = pre_r - zqcal_pkg::CNT_ONE;
		else
			pre_nxt = pre_r;
		case (st_r)
			ZQC_IDLE: begin
				if (pend_l_r || pend_s_r)
					st_nxt = ZQC_WAIT;
			end
			ZQC_WAIT: begin
				// shared resistor granted only to one device at a time
				if (banks_idle_i && pre_r == zqcal_pkg::CNT_ZERO && zq_grant_i) begin
					vld_nxt     = 1'b1;
					is_long_nxt = pend_l_r || !long_seen_r;
					cmd_nxt     = is_long_nxt ? zqcal_pkg::ZQCAL_LONG : zqcal_pkg::ZQCAL_SHORT;
					// first long after reset gets init period
					if (is_long_nxt && !long_seen_r)
						cnt_nxt = zqinit_cyc_i;
					else if (is_long_nxt)
						cnt_nxt = zqoper_cyc_i;
					else
						cnt_nxt = zqcs_cyc_i;
					// a request landing on the issue edge is kept
					if (is_long_nxt)
						pend_l_nxt = long_req_i;
					pend_s_nxt = short_req_i;
					odt_nxt    = 1'b0;
					st_nxt     = ZQC_CAL;
				end
			end
			ZQC_CAL: begin
				odt_nxt = 1'b0;
				if (cnt_r > zqcal_pkg::CNT_ONE) begin
					cnt_nxt = cnt_r - zqcal_pkg::CNT_ONE;
				end else begin
					if (is_long_r)
						long_seen_nxt = 1'b1;
					st_nxt = ZQC_IDLE;
				end
			end
			default: st_nxt = ZQC_IDLE;
		endcase
		// periodic short calibration from programmed interval
		// placed after the issue logic so a periodic set is never lost
		if (ivl_r == zqcal_pkg::CNT_ZERO) begin
			ivl_nxt = zqcs_interval_i;
			if (zqcs_interval_i != zqcal_pkg::CNT_ZERO && long_seen_r)
				pend_s_nxt = 1'b1;
		end else begin
			ivl_nxt = ivl_r - zqcal_pkg::CNT_ONE;
		end
		// status outputs registered from the next state, same timing as the state
		busy_nxt  = (st_nxt != ZQC_IDLE);
		quiet_nxt = (st_nxt == ZQC_CAL);
		dq_oe_nxt = (st_nxt != ZQC_CAL);
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r        <= ZQC_IDLE;
			long_seen_r <= 1'b0;
			is_long_r   <= 1'b0;
			cnt_r       <= zqcal_pkg::CNT_ZERO;
			pre_r       <= zqcal_pkg::CNT_ZERO;
			ivl_r       <= zqcal_pkg::CNT_ZERO;
			vld_r       <= 1'b0;
			cmd_r       <= zqcal_pkg::ZQCAL_NONE;
			odt_r       <= 1'b0;
			pend_l_r    <= 1'b0;
			pend_s_r    <= 1'b0;
			busy_r      <= 1'b0;
			quiet_r     <= 1'b0;
			dq_oe_r     <= 1'b1;
		end else if (clk_en_i) begin
			st_r        <= st_nxt;
			long_seen_r <= long_seen_nxt;
			is_long_r   <= is_long_nxt;
			cnt_r       <= cnt_nxt;
			pre_r       <= pre_nxt;
			ivl_r       <= ivl_nxt;
			vld_r       <= vld_nxt;
			cmd_r       <= cmd_nxt;
			odt_r       <= odt_nxt;
			pend_l_r    <= pend_l_nxt;
			pend_s_r    <= pend_s_nxt;
			busy_r      <= busy_nxt;
			quiet_r     <= quiet_nxt;
			dq_oe_r     <= dq_oe_nxt;
		end
	end

	// quiet channel, outputs tri-stated, cke high while calibrating
	assign link.cke         = 1'b1;
	assign link.odt         = odt_r;
	assign link.cal_cmd_vld = vld_r;
	assign link.cal_cmd     = cmd_r;
	assign link.dq_oe_ctl   = dq_oe_r;
	assign busy_o           = busy_r;
	assign quiet_o          = quiet_r;
	assign zq_hold_o        = quiet_r;
	assign first_long_done_o = long_seen_r;
endmodule

// file: tb/zqcal_assertions.sv
// link protocol checks between controller and device ends
`timescale 1ns/1ps
module zqcal_assertions (
	// clock and reset
	input wire logic                  core_clk_i,
	input wire logic                  rst_n_i,
	// link
	input wire logic                  cke,
	input wire logic                  odt,
	input wire logic                  cal_cmd_vld,
	input wire zqcal_pkg::zqcal_cmd_t cal_cmd,
	input wire logic                  dq_oe_ctl,
	input wire logic                  dev_busy
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic seen_r;
	logic seen_nxt;
	always_comb seen_nxt = seen_r | cal_cmd_vld;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			seen_r <= 1'b0;
		else
			seen_r <= seen_nxt;
	end
	sequence s_issue;
		cal_cmd_vld && !dev_busy;
	endsequence
	// bus stays released and no new command for 8 cycles after the issue
	sequence s_quiet;
		(!cal_cmd_vld && !dq_oe_ctl)[*8];
	endsequence
	property p_cke;
		cke;
	endproperty
	property p_quiet;
		s_issue |=> s_quiet;
	endproperty
	property p_busy;
		s_issue |=> dev_busy;
	endproperty
	property p_odt;
		cal_cmd_vld |-> !odt;
	endproperty
	property p_dq;
		dev_busy |-> !dq_oe_ctl;
	endproperty
	property p_first;
		cal_cmd_vld && !seen_r |-> cal_cmd == zqcal_pkg::ZQCAL_LONG;
	endproperty
	property p_kind;
		cal_cmd_vld |-> cal_cmd inside {zqcal_pkg::ZQCAL_LONG, zqcal_pkg::ZQCAL_SHORT};
	endproperty
	property p_done;
		$rose(dev_busy) |-> ##[1:400] !dev_busy;
	endproperty
	property p_overlap;
		dev_busy |-> !cal_cmd_vld;
	endproperty
	a_cke:
		assert property (p_cke) else $error("cke low");
	a_quiet:
		assert property (p_quiet) else $error("channel busy in window");
	a_busy:
		assert property (p_busy) else $error("device did not start");
	a_odt:
		assert property (p_odt) else $error("odt on at command");
	a_dq:
		assert property (p_dq) else $error("dq driven in calibration");
	a_first:
		assert property (p_first) else $error("first command not long");
	a_kind:
		assert property (p_kind) else $error("bad command code");
	a_done:
		assert property (p_done) else $error("device never finished");
	a_overlap:
		assert property (p_overlap) else $error("command while busy");
endmodule

// file: tb/testbench.sv
// self-checking bench for both calibration ends
`timescale 1ns/1ps
module testbench;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        sr_exit = 1'b0;
	logic        long_req = 1'b0;
	logic        short_req = 1'b0;
	logic        banks_idle = 1'b1;
	logic        zq_grant = 1'b1;
	logic        odt_req = 1'b1;
	logic [7:0]  tgt = 8'h80;
	logic [7:0]  exp_code;
	logic [7:0]  io_code;
	logic [23:0] p_init = 24'h0000C8;
	logic [23:0] p_oper = 24'h000096;
	logic [23:0] p_cs = 24'h000040;
	logic [23:0] p_int = 24'h000000;
	logic        cur_en;
	logic        term_en;
	logic        long_done;
	logic        cal_err;
	logic        first_done;
	logic        quiet;
	logic        busy;
	logic        zq_hold;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          seed = 32'hc0b2145f;
	int          n;
	int          w;
	int          vld_cnt = 0;

	always #10 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i)
		if (zqcal_link.cal_cmd_vld === 1'b1)
			vld_cnt++;

	zqcal_if zqcal_link ();
	zqcal_dev i_zqcal_dev (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
		.link(zqcal_link), .target_code_i(tgt), .sr_exit_i(sr_exit), .io_code_o(io_code),
		.cal_current_en_o(cur_en), .term_en_o(term_en), .long_done_o(long_done),
		.cal_err_o(cal_err));
	zqcal_ctl i_zqcal_ctl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
		.link(zqcal_link), .zqinit_cyc_i(p_init), .zqoper_cyc_i(p_oper), .zqcs_cyc_i(p_cs),
		.zqcs_interval_i(p_int), .long_req_i(long_req), .short_req_i(short_req),
		.banks_idle_i(banks_idle), .sr_exit_i(sr_exit), .zq_grant_i(zq_grant),
		.odt_req_i(odt_req), .busy_o(busy), .quiet_o(quiet), .zq_hold_o(zq_hold),
		.first_long_done_o(first_done));
	zqcal_assertions i_zqcal_assertions (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.cke(zqcal_link.cke), .odt(zqcal_link.odt), .cal_cmd_vld(zqcal_link.cal_cmd_vld),
		.cal_cmd(zqcal_link.cal_cmd), .dq_oe_ctl(zqcal_link.dq_oe_ctl),
		.dev_busy(zqcal_link.dev_busy));

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	function automatic logic [7:0] step_to(input logic [7:0] c, input logic [7:0] t);
		return (t > c) ? c + zqcal_pkg::CODE_STEP : (t < c) ? c - zqcal_pkg::CODE_STEP : c;
	endfunction

	task automatic req(input logic lng);
		long_req = lng;
		short_req = !lng;
		@(negedge core_clk_i);
		long_req = 1'b0;
		short_req = 1'b0;
	endtask

	// waits for the window, then counts its length
	task automatic meas(input logic [23:0] want);
		w = 0;
		while (quiet !== 1'b1 && w < 3000) begin
			@(negedge core_clk_i);
			w++;
		end
		n = 0;
		while (quiet === 1'b1 && n < 3000) begin
			if (zqcal_link.dev_busy === 1'b1)
				check(24'(term_en), 24'h0);
			check(24'({busy, zq_hold}), 24'h3);
			@(negedge core_clk_i);
			n++;
		end
		check(24'(n), want);
		repeat (2) @(negedge core_clk_i);
		check(24'({busy, zq_hold}), 24'h0);
	endtask

	initial begin
		p_init = 24'h0000C8 + 24'($random(seed) & 63);
		p_oper = 24'h000096 + 24'($random(seed) & 63);
		p_cs = 24'h000040 + 24'($random(seed) & 63);
		repeat (20) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		check(24'(io_code), 24'(zqcal_pkg::CODE_RESET));
		check(24'({first_done, long_done, cur_en, cal_err}), 24'h0);
		tgt = 8'($random(seed));
		// a short request before any long one must turn into the long one
		req(1'b0);
		meas(p_init);
		check(24'({first_done, long_done}), 24'h3);
		check(24'(io_code), 24'(tgt));
		check(24'({cur_en, term_en}), 24'h1);
		for (int i = 0; i < 8; i++) begin
			tgt = (i == 5) ? io_code : 8'($random(seed));
			exp_code = step_to(io_code, tgt);
			banks_idle = (i != 2);
			zq_grant = (i != 3);
			n = vld_cnt;
			req(i[0]);
			// only blocked requests wait here, so meas sees every window whole
			if (i == 2 || i == 3) begin
				repeat (30) @(negedge core_clk_i);
				check(24'(vld_cnt - n), 24'h0);
			end
			banks_idle = 1'b1;
			zq_grant = 1'b1;
			meas(i[0] ? p_oper : p_cs);
			check(24'(io_code), 24'(i[0] ? tgt : exp_code));
		end
		exp_code = io_code;
		tgt = ~io_code;
		sr_exit = 1'b1;
		@(negedge core_clk_i);
		sr_exit = 1'b0;
		repeat (40) @(negedge core_clk_i);
		check(24'(io_code), 24'(exp_code));
		sr_exit = 1'b1;
		req(1'b1);
		sr_exit = 1'b0;
		meas(p_oper);
		check(24'(w >= zqcal_pkg::XSF_CYC), 24'h1);
		check(24'(io_code), 24'(tgt));
		n = vld_cnt;
		p_int = 24'h000190;
		repeat (1000) @(negedge core_clk_i);
		p_int = 24'h000000;
		check(24'(vld_cnt > n), 24'h1);
		repeat (300) @(negedge core_clk_i);
		check(24'(cal_err), 24'h0);
		test_done;
	end

	// cut a hang short well beyond the expected run length
	initial begin
		repeat (30000) @(posedge core_clk_i);
		error_cnt++;
		test_done;
	end
endmodule
